// ---- core/submm_amp_power_telecommand.sv ----
// Behaviour
// - Only packets with process identifier 1000111 and category 1100 are accepted for this command.
// - The packet length field must read seven, the data size in bytes plus five.
// - Only packet type 11000000, a private telecommand, is taken as part of the command set.
// - Subtype 00001000 is recognised as the submillimetre amplifier power command.
// - A zero pad byte precedes a 16-bit data word holding only 0 (off) or 1 (on).
// - An accepted command drives the hardware control output at once.
// - Bit 9 of the control word at address 700 takes the inverse of the commanded value.
// - Bit 6 of the readback telemetry word mirrors control bit 9, 1 for off and 0 for on.
// - Startup and patch restart set the amplifier on by driving the control bit to 0.
`timescale 1ns/1ps
`default_nettype none
`include "submm_amp_consts.svh"

module submm_amp_power_telecommand (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic in_first,
   input wire submm_amp_pkg::byte_t in_data,
   input wire logic restart_patch,
   output logic [9:0] ctrl_addr,
   output submm_amp_pkg::word_t sensor_unit_control_word,
   output submm_amp_pkg::word_t control_readback_word,
   output logic accepted,
   output logic rejected
);
   import submm_amp_pkg::*;

   function automatic word_t crc_byte(input word_t crc, input byte_t b);
      word_t c;
      c = crc ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         c = c[15] ? ((c << 1) ^ `CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_byte

   function automatic logic field_ok(input byte_idx_t idx, input byte_t b);
      logic ok;
      ok = 1'b1;
      unique case (idx)
         `IDX_HDR0: ok = (b == `HDR0_VAL);
         `IDX_HDR1: ok = (b == `HDR1_VAL);
         `IDX_SEQ_HI: ok = ((b & `SEQ_HI_MASK) == `SEQ_HI_VAL);
         `IDX_LEN_HI: ok = (b == `LEN_HI_VAL);
         `IDX_LEN_LO: ok = (b == `LEN_LO_VAL);
         `IDX_SEC0: ok = (b == `SEC0_VAL);
         `IDX_TYPE: ok = (b == `TYPE_VAL);
         `IDX_SUBTYPE: ok = (b == `SUBTYPE_VAL);
         `IDX_PAD: ok = (b == `PAD_VAL);
         `IDX_DATA_HI: ok = (b == 8'h00);
         `IDX_DATA_LO: ok = (b[7:1] == 7'h00);
         default: ok = 1'b1;
      endcase
      return ok;
   endfunction : field_ok

   byte_idx_t idx_q;
   byte_idx_t idx_d;
   logic ok_q;
   logic ok_d;
   word_t crc_q;
   word_t crc_d;
   logic amp_off_q;
   logic cmd_q;
   logic accepted_q;
   logic rejected_q;

   // a new first byte always restarts framing, so a truncated packet cannot poison the next
   wire byte_idx_t cur_idx = in_first ? `IDX_HDR0 : idx_q;
   wire word_t crc_base = in_first ? `CRC_INIT : crc_q;
   wire logic ok_base = in_first ? 1'b1 : ok_q;
   // bytes past the last one before a new first byte are surplus and ignored; the packet was judged at its last byte
   wire logic overrun = (cur_idx > `IDX_LAST);
   wire logic byte_ok = field_ok(cur_idx, in_data) && !overrun;
   wire logic last_byte = in_valid && (cur_idx == `IDX_LAST);
   // crc run over the checksum bytes too leaves a zero residue
   wire logic crc_good = (crc_d == 16'h0000);
   wire logic good_pkt = last_byte && ok_d && crc_good;
   wire logic bad_pkt = last_byte && !good_pkt;
   // command bit sits two bytes before the end, under the checksum;
   // it is held until the last byte proves the packet sound
   wire logic take_cmd = in_valid && (cur_idx == `IDX_DATA_LO);

   assign crc_d = crc_byte(crc_base, in_data);
   assign ok_d = ok_base && byte_ok;
   assign idx_d = overrun ? cur_idx : cur_idx + 4'd1;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         idx_q <= 4'hF;
         ok_q <= 1'b0;
         crc_q <= `CRC_INIT;
      end else if (in_valid) begin
         idx_q <= idx_d;
         ok_q <= ok_d;
         crc_q <= crc_d;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_q <= 1'b1;
      end else if (take_cmd) begin
         cmd_q <= in_data[0];
      end
   end

   // idx_q resets to the overrun value: nothing counts until a first byte arrives
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         amp_off_q <= `AMP_OFF_RESET;
      end else if (restart_patch) begin
         amp_off_q <= `AMP_OFF_RESET;
      end else if (good_pkt) begin
         amp_off_q <= ~cmd_q;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         accepted_q <= 1'b0;
         rejected_q <= 1'b0;
      end else begin
         accepted_q <= good_pkt && !restart_patch;
         rejected_q <= bad_pkt;
      end
   end

   assign ctrl_addr = `SENSOR_UNIT_CONTROL_WORD_ADDR;
   assign sensor_unit_control_word = word_t'(amp_off_q) << `SENSOR_UNIT_CONTROL_WORD_AMP_BIT;
   assign control_readback_word = word_t'(amp_off_q) << `READBACK_AMP_BIT;
   assign accepted = accepted_q;
   assign rejected = rejected_q;

   property p_apply;
      @(posedge clock) disable iff (rst)
      good_pkt && !restart_patch |=> accepted && sensor_unit_control_word[9] == !$past(cmd_q);
   endproperty
   a_apply: assert property (p_apply) else $error("accepted command not applied next cycle");

   property p_inverse;
      @(posedge clock) disable iff (rst)
      (good_pkt && !restart_patch && cmd_q) |=> sensor_unit_control_word == 16'h0000;
   endproperty
   a_inverse: assert property (p_inverse) else $error("power on did not clear control bit");

   property p_readback;
      @(posedge clock) disable iff (rst)
      control_readback_word[6] == sensor_unit_control_word[9] && control_readback_word[15:7] == 9'h000;
   endproperty
   a_readback: assert property (p_readback) else $error("readback bit does not mirror control bit");

   property p_restart;
      @(posedge clock) disable iff (rst)
      restart_patch |=> sensor_unit_control_word[9] == 1'b0 && !accepted;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not power amplifier on");

   property p_hold_on_reject;
      @(posedge clock) disable iff (rst)
      bad_pkt && !restart_patch |=> rejected && $stable(sensor_unit_control_word);
   endproperty
   a_hold_on_reject: assert property (p_hold_on_reject) else $error("rejected packet changed control");

   property p_crc_bad;
      @(posedge clock) disable iff (rst)
      last_byte && crc_d != 16'h0000 |=> !accepted ##1 !accepted;
   endproperty
   a_crc_bad: assert property (p_crc_bad) else $error("bad checksum accepted");

   property p_apid;
      @(posedge clock) disable iff (rst)
      in_valid && !in_first && idx_q == 4'd1 && in_data != 8'h7C |=> !ok_q;
   endproperty
   a_apid: assert property (p_apid) else $error("wrong process id or category kept");

   property p_length;
      @(posedge clock) disable iff (rst)
      in_valid && !in_first && idx_q == 4'd5 && in_data != 8'h07 ##1 !in_first[*8] |=> !accepted;
   endproperty
   a_length: assert property (p_length) else $error("wrong length accepted");

   property p_type;
      @(posedge clock) disable iff (rst)
      in_valid && !in_first && idx_q == 4'd7 && in_data != 8'hC0 |=> !ok_q;
   endproperty
   a_type: assert property (p_type) else $error("non-private packet type kept");

   property p_subtype;
      @(posedge clock) disable iff (rst)
      in_valid && !in_first && idx_q == 4'd8 && in_data != 8'h08 |=> !ok_q;
   endproperty
   a_subtype: assert property (p_subtype) else $error("other subtype kept");

   property p_data;
      @(posedge clock) disable iff (rst)
      in_valid && !in_first && idx_q == 4'd11 && in_data[7:1] != 7'h00 |=> !ok_q;
   endproperty
   a_data: assert property (p_data) else $error("out of range data kept");

   property p_one_shot;
      @(posedge clock) disable iff (rst)
      accepted || rejected |=> !accepted && !rejected;
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("answer pulse longer than one cycle");

   // only an accepted command or a restart may move the control bit
   property p_hold_else;
      @(posedge clock) disable iff (rst)
      $changed(sensor_unit_control_word) |-> $past(good_pkt) || $past(restart_patch);
   endproperty
   a_hold_else: assert property (p_hold_else) else $error("control word changed without a command");

   c_power_off: cover property (@(posedge clock) disable iff (rst) accepted && sensor_unit_control_word[9]);
   c_power_on: cover property (@(posedge clock) disable iff (rst) accepted && !sensor_unit_control_word[9]);
   c_reject: cover property (@(posedge clock) disable iff (rst) rejected);
   c_restart: cover property (@(posedge clock) disable iff (rst) sensor_unit_control_word[9] ##1 restart_patch);
   c_restart_wins: cover property (@(posedge clock) disable iff (rst) last_byte && restart_patch);

endmodule : submm_amp_power_telecommand

`default_nettype wire

// ---- include/submm_amp_consts.svh ----
`ifndef SUBMM_AMP_CONSTS_SVH
`define SUBMM_AMP_CONSTS_SVH

// packet bytes, in arrival order
`define PKT_BYTES 14
`define IDX_HDR0 4'd0
`define IDX_HDR1 4'd1
`define IDX_SEQ_HI 4'd2
`define IDX_LEN_HI 4'd4
`define IDX_LEN_LO 4'd5
`define IDX_SEC0 4'd6
`define IDX_TYPE 4'd7
`define IDX_SUBTYPE 4'd8
`define IDX_PAD 4'd9
`define IDX_DATA_HI 4'd10
`define IDX_DATA_LO 4'd11
`define IDX_LAST 4'd13
// version 000, type 1, header flag 1, process id 1000111, category 1100
`define HDR0_VAL 8'h1C
`define HDR1_VAL 8'h7C
// sequence flags 11 and three ground-source zeros
`define SEQ_HI_MASK 8'hF8
`define SEQ_HI_VAL 8'hC0
// length = data bytes + 5
`define LEN_HI_VAL 8'h00
`define LEN_LO_VAL 8'h07
// service version 000, checksum flag 1, ack 0001
`define SEC0_VAL 8'h11
`define TYPE_VAL 8'hC0
`define SUBTYPE_VAL 8'h08
`define PAD_VAL 8'h00
// packet error control
`define CRC_POLY 16'h1021
`define CRC_INIT 16'hFFFF
// control word placement
`define SENSOR_UNIT_CONTROL_WORD_ADDR 10'h2BC
`define SENSOR_UNIT_CONTROL_WORD_AMP_BIT 9
`define READBACK_AMP_BIT 6
// powered on after startup: hardware 0 = on
`define AMP_OFF_RESET 1'b0

`endif

// ---- include/submm_amp_pkg.sv ----
`default_nettype none
package submm_amp_pkg;
   typedef logic [3:0] byte_idx_t;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
endpackage : submm_amp_pkg
`default_nettype wire

// ---- test/submm_amp_power_telecommand_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module submm_amp_power_telecommand_tb_top;
   import submm_amp_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic restart_patch = 1'b0;
   logic in_valid;
   logic in_first;
   byte_t in_data;
   logic [9:0] ctrl_addr;
   word_t sensor_unit_control_word;
   word_t control_readback_word;
   logic accepted;
   logic rejected;
   int mismatches = 0;
   int n_compared = 0;
   always #2.5 clock = ~clock;
   submm_cmd_source src (.clock(clock), .in_valid(in_valid), .in_first(in_first), .in_data(in_data));
   submm_amp_power_telecommand dut (.clock(clock), .rst(rst), .in_valid(in_valid), .in_first(in_first),
      .in_data(in_data), .restart_patch(restart_patch), .ctrl_addr(ctrl_addr),
      .sensor_unit_control_word(sensor_unit_control_word), .control_readback_word(control_readback_word),
      .accepted(accepted), .rejected(rejected));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // the answer is only one cycle wide, so look right after the edge and once more
   task automatic after_pkt(input logic acc, input logic rej, input logic off);
      #1;
      chk({14'h0000, accepted, rejected}, {14'h0000, acc, rej});
      chk(sensor_unit_control_word, {6'h00, off, 9'h000});
      chk(control_readback_word, {9'h000, off, 6'h00});
      @(posedge clock);
      #1;
      chk({15'h0000, accepted | rejected}, 16'h0000);
   endtask : after_pkt
   task automatic test_reset();
      chk({6'h00, ctrl_addr}, 16'h02BC);
      chk(sensor_unit_control_word | control_readback_word, 16'h0000);
      chk({15'h0000, accepted | rejected}, 16'h0000);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_commands();
      src.send(8'h00, -1, 8'h00, 1'b0);
      after_pkt(1'b1, 1'b0, 1'b1);
      src.send(8'h01, -1, 8'h00, 1'b0);
      after_pkt(1'b1, 1'b0, 1'b0);
      src.send(8'h00, -1, 8'h00, 1'b0);
      after_pkt(1'b1, 1'b0, 1'b1);
      $display("test_commands done");
   endtask : test_commands
   // each bad packet asks for on, so a wrongly taken one would show
   task automatic test_refusals();
      int idx [12] = '{0, 1, 2, 4, 5, 6, 7, 8, 9, 10, 11, -1};
      byte_t msk [12] = '{8'h01, 8'h01, 8'h08, 8'h01, 8'h01, 8'h01, 8'h01, 8'h0F, 8'h01, 8'h01, 8'h02, 8'h00};
      for (int n = 0; n < 12; n++) begin
         src.send(8'h01, idx[n], msk[n], n == 11);
         after_pkt(1'b0, 1'b1, 1'b1);
      end
      $display("test_refusals done");
   endtask : test_refusals
   task automatic test_restart();
      @(posedge clock);
      restart_patch <= 1'b1;
      @(posedge clock);
      restart_patch <= 1'b0;
      #1;
      chk(sensor_unit_control_word | control_readback_word, 16'h0000);
      src.send(8'h00, -1, 8'h00, 1'b0);
      after_pkt(1'b1, 1'b0, 1'b1);
      // restart on the edge of the last byte must beat the off command
      fork
         src.send(8'h00, -1, 8'h00, 1'b0);
         begin
            repeat (14) @(posedge clock);
            restart_patch <= 1'b1;
            @(posedge clock);
            restart_patch <= 1'b0;
         end
      join
      #1;
      chk({14'h0000, accepted, rejected}, 16'h0000);
      chk(sensor_unit_control_word | control_readback_word, 16'h0000);
      $display("test_restart done");
   endtask : test_restart
   task automatic test_mid_reset();
      src.send(8'h00, -1, 8'h00, 1'b0);
      after_pkt(1'b1, 1'b0, 1'b1);
      @(posedge clock);
      rst <= 1'b1;
      #1;
      chk(sensor_unit_control_word | control_readback_word, 16'h0000);
      @(posedge clock);
      rst <= 1'b0;
      #1;
      chk({15'h0000, accepted | rejected}, 16'h0000);
      src.send(8'h00, -1, 8'h00, 1'b0);
      after_pkt(1'b1, 1'b0, 1'b1);
      $display("test_mid_reset done");
   endtask : test_mid_reset
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (6) @(posedge clock);
      test_reset();
      rst <= 1'b0;
      test_commands();
      test_refusals();
      test_restart();
      test_mid_reset();
      tally_and_finish();
   end
   initial begin
      #100000;
      mismatches++;
      tally_and_finish();
   end
endmodule : submm_amp_power_telecommand_tb_top
`default_nettype wire

// ---- test/submm_cmd_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module submm_cmd_source (
   input wire logic clock,
   output logic in_valid,
   output logic in_first,
   output submm_amp_pkg::byte_t in_data
);
   import submm_amp_pkg::*;
   logic [10:0] seq_q = 11'h000; // one counter for our one id and category pair
   initial begin
      in_valid = 1'b0;
      in_first = 1'b0;
      in_data = 8'h00;
   end
   task automatic send(input byte_t lo, input int bi, input byte_t bm, input logic bad_crc);
      byte_t p [14];
      word_t c;
      p = '{8'h1C, 8'h7C, {5'h18, seq_q[10:8]}, seq_q[7:0], 8'h00, 8'h07,
         8'h11, 8'hC0, 8'h08, 8'h00, 8'h00, lo, 8'h00, 8'h00};
      if (bi >= 0)
         p[bi] = p[bi] ^ bm;
      c = 16'hFFFF;
      for (int i = 0; i < 12; i++) begin
         c = c ^ {p[i], 8'h00};
         for (int k = 0; k < 8; k++)
            c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
      end
      p[12] = c[15:8];
      p[13] = c[7:0] ^ {7'h00, bad_crc};
      seq_q = seq_q + 11'h001;
      for (int i = 0; i < 14; i++) begin
         @(posedge clock);
         in_valid <= 1'b1;
         in_first <= (i == 0);
         in_data <= p[i];
      end
      @(posedge clock);
      in_valid <= 1'b0;
      in_first <= 1'b0;
      in_data <= ~p[13]; // released bus must not hold a stale byte
   endtask : send
endmodule : submm_cmd_source
`default_nettype wire
